/* File: dv/dsp_jtag_host.sv */
//
// Purpose: test clock master model for the scan port
// Assumes: tdo changes on the falling test clock edge
// Notes:   test clock stands still between frames
//
`timescale 1ns/1ps
module dsp_jtag_host (
  input  wire logic tdo_in,
  input  wire logic tdo_oe_in,
  output logic      tclk_out,
  output logic      tms_out,
  output logic      tdi_out,
  output logic      trst_n_out
);
  localparam int HALF = 3;

  initial begin
    tclk_out   = 1'b0;
    tms_out    = 1'b1;
    tdi_out    = 1'b0;
    trst_n_out = 1'b1;
  end

  // ***************************************************************
  // link cycles
  // ***************************************************************
  // tdo is read at the rising edge, only while it is driven
  task automatic tick(input logic m, input logic d, output logic q);
    tms_out  = m;
    tdi_out  = d;
    #HALF;
    q        = tdo_oe_in ? tdo_in : 1'bx;
    tclk_out = 1'b1;
    #HALF;
    tclk_out = 1'b0;
  endtask

  // n tms highs, then one low to reach the idle state
  task automatic idle(input int n);
    logic q;
    repeat (n) tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
  endtask

  // shift n bits lsb first from idle back to idle
  task automatic shift(input logic ir, input logic [63:0] din,
                       input int n, output logic [63:0] dout);
    logic q;
    dout = '0;
    tick(1'b1, 1'b0, q);
    if (ir) tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
    tick(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], q);
      dout[i] = q;
    end
    tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
    // data line is not held after the frame
    tdi_out = ~din[n-1];
  endtask

  task automatic pulse_trst();
    trst_n_out = 1'b0;
    #20;
    trst_n_out = 1'b1;
  endtask
endmodule

/* File: dv/tb.sv */
//
// Purpose: self-checking bench for the dual serial port block
// Assumes: pin changes settle within four enabled clock cycles
// Notes:   scan traffic comes from the host model
//
`timescale 1ns/1ps
module tb;
  localparam int LIMIT = 20000;

  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        mode = 1'b0;
  logic        pd_n = 1'b1;
  logic [4:0]  oe_n = 5'h00;
  logic        sel = 1'b1;
  logic [1:0]  lo = 2'h0;
  logic [1:0]  hi = 2'h0;
  logic        tclk, tms, tdi, trst_n, tdo, tdo_oe, ser_en, ck_en;
  logic [6:0]  addr;
  logic [4:0]  b_oe, b_gate;
  logic        b_lvl, f_oe, f_gate, f_lvl, fn_lvl, c_gated, c_lvl;
  logic [63:0] got;
  logic [63:0] cfg;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  wire  [26:0] snap = {ser_en, addr, ck_en, b_oe, b_gate, b_lvl, f_oe,
                       f_gate, f_lvl, fn_lvl, c_gated, c_lvl, tdo_oe};

  always #5 clk = ~clk;

  dsp_top dsp_top_i (
    .clk_in                  (clk),
    .reset_n_in              (rst_n),
    .clk_en_in               (1'b1),
    .disable_mode_pin_in     (mode),
    .power_down_n_in         (pd_n),
    .bank_output_enable_n_in (oe_n),
    .port_sel_in             (sel),
    .trst_n_in               (trst_n),
    .tclk_in                 (tclk),
    .tms_in                  (tms),
    .tdi_in                  (tdi),
    .bus_addr_strap_lo_in    (lo),
    .bus_addr_strap_hi_in    (hi),
    .tdo_out                 (tdo),
    .tdo_oe_out              (tdo_oe),
    .serial_bus_en_out       (ser_en),
    .bus_addr_out            (addr),
    .clk_inputs_en_out       (ck_en),
    .bank_oe_out             (b_oe),
    .bank_gate_out           (b_gate),
    .bank_stop_level_out     (b_lvl),
    .fb_oe_out               (f_oe),
    .fb_gate_out             (f_gate),
    .fb_stop_level_out       (f_lvl),
    .fb_n_stop_level_out     (fn_lvl),
    .cfg_gated_out           (c_gated),
    .cfg_level_out           (c_lvl)
  );

  dsp_jtag_host dsp_jtag_host_i (
    .tdo_in     (tdo),
    .tdo_oe_in  (tdo_oe),
    .tclk_out   (tclk),
    .tms_out    (tms),
    .tdi_out    (tdi),
    .trst_n_out (trst_n)
  );

  // ***************************************************************
  // helpers
  // ***************************************************************
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  task automatic finish_test();
    $display("compares %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // select the config chain, write v and read back the old word
  task automatic load_cfg(input logic [63:0] v);
    logic [63:0] q;
    dsp_jtag_host_i.shift(1'b1, {60'h0, dsp_pkg::IR_CFG}, 4, q);
    chk(q, {60'h0, dsp_pkg::IR_CAPTURE});
    dsp_jtag_host_i.shift(1'b0, v, 64, q);
    chk(q, cfg);
    cfg = v;
    wait_clk(8);
  endtask

  task automatic check_stop();
    logic       g;
    logic       fd;
    logic       lv;
    logic [4:0] dis;
    logic [4:0] e;
    g   = mode | cfg[dsp_pkg::CFG_MODE];
    lv  = cfg[dsp_pkg::CFG_LVL];
    fd  = ~pd_n;
    dis = oe_n | {5{fd}};
    e   = ~dis | {5{g}};
    chk(b_oe, e);
    e   = dis & {5{g}};
    chk(b_gate, e);
    chk({f_oe, f_gate}, {~fd | g, fd & g});
    chk({b_lvl, f_lvl, fn_lvl}, {~lv, ~lv, lv});
    chk(ck_en, pd_n);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      error_cnt++;
      finish_test();
    end
  end

  // ***************************************************************
  // tests
  // ***************************************************************
  initial begin
    cfg = dsp_pkg::CFG_RESET;
    wait_clk(20);
    chk(snap, {1'b0, dsp_pkg::BUS_ADDR_BASE, 11'h0, 3'h4, 5'h10});
    rst_n = 1'b1;
    wait_clk(1);
    chk(snap, {1'b0, dsp_pkg::BUS_ADDR_BASE, 11'h0, 3'h4, 5'h10});
    done("reset");
    dsp_jtag_host_i.idle(5);
    chk(tdo_oe, 1'b0);
    dsp_jtag_host_i.shift(1'b1, {60'h0, dsp_pkg::IR_BYPASS}, 4, got);
    chk(got, {60'h0, dsp_pkg::IR_CAPTURE});
    dsp_jtag_host_i.shift(1'b0, 64'hD, 4, got);
    chk(got, 64'hA);
    chk(tdo_oe, 1'b0);
    done("bypass");
    for (int c = 0; c < 4; c++) begin
      load_cfg(64'h1 | (64'(c) << dsp_pkg::CFG_LVL));
      chk({c_gated, c_lvl}, 64'(c));
      for (int m = 0; m < 8; m++) begin
        mode = m[0];
        pd_n = m[1];
        oe_n = m[2] ? 5'h16 : 5'h09;
        wait_clk(4);
        check_stop();
      end
    end
    mode = 1'b0;
    pd_n = 1'b1;
    oe_n = 5'h00;
    done("stop");
    // each source must drop the config chain back to bypass
    for (int k = 0; k < 3; k++) begin
      dsp_jtag_host_i.shift(1'b1, {60'h0, dsp_pkg::IR_CFG}, 4, got);
      if (k == 0) dsp_jtag_host_i.idle(5);
      if (k == 1) dsp_jtag_host_i.pulse_trst();
      if (k == 2) begin
        wait_clk(1);
        sel = 1'b0;
        for (int a = 0; a < 9; a++) begin
          lo = 2'(a % 3);
          hi = 2'(a / 3);
          wait_clk(4);
          chk({ser_en, addr}, {1'b1, dsp_pkg::BUS_ADDR_BASE +
              7'(3 * (a / 3) + a % 3)});
        end
        dsp_jtag_host_i.idle(0);
        sel = 1'b1;
        lo  = 2'h0;
        hi  = 2'h2;
        wait_clk(4);
        chk({ser_en, addr}, {1'b0, dsp_pkg::BUS_ADDR_BASE + 7'h8});
      end
      if (k != 0) dsp_jtag_host_i.idle(0);
      dsp_jtag_host_i.shift(1'b0, 64'h0, 2, got);
      chk(got, 64'h0);
    end
    done("tap reset");
    finish_test();
  end
endmodule

/* File: src/dsp_pkg.sv */
//
// Purpose: shared constants and types for the dual serial port block
// Assumes: four-bit instruction register, 64-bit configuration word
// Notes:   bus address base is an arbitrary neutral value
//
package dsp_pkg;

  // ***************************************************************
  // widths and field positions
  // ***************************************************************
  localparam int NBANK    = 5;
  localparam int IR_W     = 4;
  localparam int CFG_W    = 64;
  localparam int CFG_MODE = 59;
  localparam int CFG_LVL  = 58;
  localparam int NSYNC    = 13;

  // ***************************************************************
  // instruction codes and reset values
  // ***************************************************************
  localparam logic [IR_W-1:0]  IR_CFG     = 4'h2;
  localparam logic [IR_W-1:0]  IR_BYPASS  = 4'hF;
  localparam logic [IR_W-1:0]  IR_CAPTURE = 4'h1;
  localparam logic [CFG_W-1:0] CFG_RESET  = 64'h0;

  // ***************************************************************
  // serial bus address
  // ***************************************************************
  // arbitrary base address
  localparam logic [6:0] BUS_ADDR_BASE = 7'h40;
  localparam logic [3:0] STRAP_WEIGHT  = 4'h3;

  // ***************************************************************
  // test port controller states
  // ***************************************************************
  typedef enum logic [3:0] {
    ST_TLR    = 4'hF,
    ST_RTI    = 4'hC,
    ST_SEL_DR = 4'h7,
    ST_CAP_DR = 4'h6,
    ST_SH_DR  = 4'h2,
    ST_EX1_DR = 4'h1,
    ST_PA_DR  = 4'h3,
    ST_EX2_DR = 4'h0,
    ST_UP_DR  = 4'h5,
    ST_SEL_IR = 4'h4,
    ST_CAP_IR = 4'hE,
    ST_SH_IR  = 4'hA,
    ST_EX1_IR = 4'h9,
    ST_PA_IR  = 4'hB,
    ST_EX2_IR = 4'h8,
    ST_UP_IR  = 4'hD
  } dsp_tap_state_t;

endpackage

/* File: src/dsp_tap_fsm.sv */
//
// Purpose: sixteen-state test port controller
// Assumes: reset input already merges every asynchronous reset source
// Notes:   runs on the test clock only
//
`timescale 1ns/1ps
module dsp_tap_fsm (
  input  wire logic  tclk_in,
  input  wire logic  tap_rst_n_in,
  input  wire logic  tms_in,
  dsp_tap_if.fsm     tap_if
);

  dsp_pkg::dsp_tap_state_t state_reg;
  dsp_pkg::dsp_tap_state_t state_next;

  assign tap_if.state = state_reg;

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    case (state_reg)
      dsp_pkg::ST_TLR:
        state_next = tms_in ? dsp_pkg::ST_TLR : dsp_pkg::ST_RTI;
      dsp_pkg::ST_RTI:
        state_next = tms_in ? dsp_pkg::ST_SEL_DR : dsp_pkg::ST_RTI;
      dsp_pkg::ST_SEL_DR:
        state_next = tms_in ? dsp_pkg::ST_SEL_IR : dsp_pkg::ST_CAP_DR;
      dsp_pkg::ST_CAP_DR:
        state_next = tms_in ? dsp_pkg::ST_EX1_DR : dsp_pkg::ST_SH_DR;
      dsp_pkg::ST_SH_DR:
        state_next = tms_in ? dsp_pkg::ST_EX1_DR : dsp_pkg::ST_SH_DR;
      dsp_pkg::ST_EX1_DR:
        state_next = tms_in ? dsp_pkg::ST_UP_DR : dsp_pkg::ST_PA_DR;
      dsp_pkg::ST_PA_DR:
        state_next = tms_in ? dsp_pkg::ST_EX2_DR : dsp_pkg::ST_PA_DR;
      dsp_pkg::ST_EX2_DR:
        state_next = tms_in ? dsp_pkg::ST_UP_DR : dsp_pkg::ST_SH_DR;
      dsp_pkg::ST_UP_DR:
        state_next = tms_in ? dsp_pkg::ST_SEL_DR : dsp_pkg::ST_RTI;
      dsp_pkg::ST_SEL_IR:
        state_next = tms_in ? dsp_pkg::ST_TLR : dsp_pkg::ST_CAP_IR;
      dsp_pkg::ST_CAP_IR:
        state_next = tms_in ? dsp_pkg::ST_EX1_IR : dsp_pkg::ST_SH_IR;
      dsp_pkg::ST_SH_IR:
        state_next = tms_in ? dsp_pkg::ST_EX1_IR : dsp_pkg::ST_SH_IR;
      dsp_pkg::ST_EX1_IR:
        state_next = tms_in ? dsp_pkg::ST_UP_IR : dsp_pkg::ST_PA_IR;
      dsp_pkg::ST_PA_IR:
        state_next = tms_in ? dsp_pkg::ST_EX2_IR : dsp_pkg::ST_PA_IR;
      dsp_pkg::ST_EX2_IR:
        state_next = tms_in ? dsp_pkg::ST_UP_IR : dsp_pkg::ST_SH_IR;
      dsp_pkg::ST_UP_IR:
        state_next = tms_in ? dsp_pkg::ST_SEL_DR : dsp_pkg::ST_RTI;
      default:
        state_next = dsp_pkg::ST_TLR;
    endcase
  end

  // tms sampled on the rising test clock edge
  always_ff @(posedge tclk_in or negedge tap_rst_n_in) begin
    if (!tap_rst_n_in) begin
      state_reg <= dsp_pkg::ST_TLR;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule

/* File: src/dsp_tap_if.sv */
//
// Purpose: carries the test port controller state between modules
// Assumes: one controller per block
// Notes:   none
//
`timescale 1ns/1ps
interface dsp_tap_if;
  dsp_pkg::dsp_tap_state_t state;
  modport fsm  (output state);
  modport core (input  state);
endinterface

/* File: src/dsp_top.sv */
//
// Purpose: shared test port / serial bus pins and output stop control
// Assumes: three-level straps arrive decoded as 0 low, 1 mid, 2 high
// Notes:   configuration word crosses to clk_in by toggle handshake
//
// How it works
// - mode pin or bit 59 selects gated stop
// - bit 58 sets stop levels, feedback complement opposite
// - otherwise disabled outputs go high impedance
// - applies to bank enables and power down
// - select high routes pins to test port
// - select low gives serial bus, resets controller
// - test reset pin low resets scan logic asynchronously
// - controller advances on rising test clock with tms
// - tdi captured on rising test clock
// - tdo changes on falling test clock
// - tdo high impedance unless shifting out
// - serial address from straps, ignored in test mode
// - power down stops inputs, switching and outputs
//
`timescale 1ns/1ps
module dsp_top (
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        clk_en_in,
  input  wire logic        disable_mode_pin_in,
  input  wire logic        power_down_n_in,
  input  wire logic [4:0]  bank_output_enable_n_in,
  input  wire logic        port_sel_in,
  input  wire logic        trst_n_in,
  input  wire logic        tclk_in,
  input  wire logic        tms_in,
  input  wire logic        tdi_in,
  input  wire logic [1:0]  bus_addr_strap_lo_in,
  input  wire logic [1:0]  bus_addr_strap_hi_in,
  output logic             tdo_out,
  output logic             tdo_oe_out,
  output logic             serial_bus_en_out,
  output logic [6:0]       bus_addr_out,
  output logic             clk_inputs_en_out,
  output logic [4:0]       bank_oe_out,
  output logic [4:0]       bank_gate_out,
  output logic             bank_stop_level_out,
  output logic             fb_oe_out,
  output logic             fb_gate_out,
  output logic             fb_stop_level_out,
  output logic             fb_n_stop_level_out,
  output logic             cfg_gated_out,
  output logic             cfg_level_out
);

  // ***************************************************************
  // test clock domain
  // ***************************************************************
  logic                            tap_rst_n;
  logic [dsp_pkg::IR_W-1:0]        ir_sh_reg;
  logic [dsp_pkg::IR_W-1:0]        ir_reg;
  logic [dsp_pkg::CFG_W-1:0]       cfg_sh_reg;
  logic [dsp_pkg::CFG_W-1:0]       cfg_reg;
  logic                            bypass_reg;
  logic                            cfg_tgl_reg;
  logic                            tdo_reg;
  logic                            tdo_oe_reg;
  logic                            shifting;
  logic                            sh_bit;
  logic                            cfg_sel;
  dsp_pkg::dsp_tap_state_t         st;

  dsp_tap_if tap_if ();

  // pin reset, select low and block reset all force the controller
  assign tap_rst_n = trst_n_in & port_sel_in & reset_n_in;

  dsp_tap_fsm u_fsm (
    .tclk_in      (tclk_in),
    .tap_rst_n_in (tap_rst_n),
    .tms_in       (tms_in),
    .tap_if       (tap_if.fsm)
  );

  assign st      = tap_if.state;
  assign cfg_sel = (ir_reg == dsp_pkg::IR_CFG);

  assign shifting = (st == dsp_pkg::ST_SH_IR) ||
                    (st == dsp_pkg::ST_SH_DR);

  always_comb begin
    if (st == dsp_pkg::ST_SH_IR) begin
      sh_bit = ir_sh_reg[0];
    end else if (cfg_sel) begin
      sh_bit = cfg_sh_reg[0];
    end else begin
      sh_bit = bypass_reg;
    end
  end

  // instruction register, tdi taken on the rising edge
  always_ff @(posedge tclk_in or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      ir_sh_reg <= dsp_pkg::IR_BYPASS;
      ir_reg    <= dsp_pkg::IR_BYPASS;
    end else begin
      case (st)
        dsp_pkg::ST_TLR: begin
          ir_reg <= dsp_pkg::IR_BYPASS;
        end
        dsp_pkg::ST_CAP_IR: begin
          ir_sh_reg <= dsp_pkg::IR_CAPTURE;
        end
        dsp_pkg::ST_SH_IR: begin
          ir_sh_reg <= {tdi_in, ir_sh_reg[dsp_pkg::IR_W-1:1]};
        end
        dsp_pkg::ST_UP_IR: begin
          ir_reg <= ir_sh_reg;
        end
        default: begin
          ir_reg <= ir_reg;
        end
      endcase
    end
  end

  // data registers: bypass bit and configuration shifter
  always_ff @(posedge tclk_in or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      bypass_reg <= 1'h0;
      cfg_sh_reg <= dsp_pkg::CFG_RESET;
    end else begin
      if (st == dsp_pkg::ST_CAP_DR) begin
        bypass_reg <= 1'h0;
        cfg_sh_reg <= cfg_reg;
      end else if (st == dsp_pkg::ST_SH_DR) begin
        bypass_reg <= tdi_in;
        if (cfg_sel) begin
          cfg_sh_reg <= {tdi_in, cfg_sh_reg[dsp_pkg::CFG_W-1:1]};
        end
      end
    end
  end

  // programmed word survives test port resets; only block reset
  // clears it
  always_ff @(posedge tclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cfg_reg     <= dsp_pkg::CFG_RESET;
      cfg_tgl_reg <= 1'h0;
    end else if (tap_rst_n && st == dsp_pkg::ST_UP_DR && cfg_sel) begin
      cfg_reg     <= cfg_sh_reg;
      cfg_tgl_reg <= ~cfg_tgl_reg;
    end
  end

  // falling edge output stage
  always_ff @(negedge tclk_in or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      tdo_reg    <= 1'h0;
      tdo_oe_reg <= 1'h0;
    end else begin
      tdo_reg    <= sh_bit;
      tdo_oe_reg <= shifting;
    end
  end

  assign tdo_out    = tdo_reg;
  assign tdo_oe_out = tdo_oe_reg;

  // ***************************************************************
  // pin synchronisers into clk_in
  // ***************************************************************
  logic [dsp_pkg::NSYNC-1:0] raw;
  logic [dsp_pkg::NSYNC-1:0] sync1_reg;
  logic [dsp_pkg::NSYNC-1:0] sync2_reg;

  assign raw = {cfg_tgl_reg, bus_addr_strap_hi_in,
                bus_addr_strap_lo_in, bank_output_enable_n_in,
                port_sel_in, power_down_n_in, disable_mode_pin_in};

  // select flops reset high so bus mode does not flash on after reset
  genvar gi;
  generate
    for (gi = 0; gi < dsp_pkg::NSYNC; gi++) begin : g_sync
      always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          sync1_reg[gi] <= (gi == 2) ? 1'h1 : 1'h0;
          sync2_reg[gi] <= (gi == 2) ? 1'h1 : 1'h0;
        end else if (clk_en_in) begin
          sync1_reg[gi] <= raw[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  logic       mode_s;
  logic       pd_n_s;
  logic       sel_s;
  logic [4:0] oe_n_s;
  logic [1:0] lo_s;
  logic [1:0] hi_s;
  logic       tgl_s;

  assign mode_s = sync2_reg[0];
  assign pd_n_s = sync2_reg[1];
  assign sel_s  = sync2_reg[2];
  assign oe_n_s = sync2_reg[7:3];
  assign lo_s   = sync2_reg[9:8];
  assign hi_s   = sync2_reg[11:10];
  assign tgl_s  = sync2_reg[12];

  // ***************************************************************
  // configuration bits crossing
  // ***************************************************************
  logic tgl_seen_reg;
  logic cfg_mode_reg;
  logic cfg_level_reg;

  // word is stable for many test clocks after each toggle
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tgl_seen_reg  <= 1'h0;
      cfg_mode_reg  <= 1'h0;
      cfg_level_reg <= 1'h0;
    end else if (clk_en_in) begin
      tgl_seen_reg <= tgl_s;
      if (tgl_s != tgl_seen_reg) begin
        cfg_mode_reg  <= cfg_reg[dsp_pkg::CFG_MODE];
        cfg_level_reg <= cfg_reg[dsp_pkg::CFG_LVL];
      end
    end
  end

  assign cfg_gated_out = cfg_mode_reg;
  assign cfg_level_out = cfg_level_reg;

  // ***************************************************************
  // output stop control
  // ***************************************************************
  logic       gated;
  logic       pd;
  logic [4:0] bank_dis;

  assign gated    = mode_s | cfg_mode_reg;
  assign pd       = ~pd_n_s;
  assign bank_dis = oe_n_s | {5{pd}};

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bank_oe_out   <= 5'h00;
      bank_gate_out <= 5'h00;
      fb_oe_out     <= 1'h0;
      fb_gate_out   <= 1'h0;
    end else if (clk_en_in) begin
      bank_oe_out   <= ~bank_dis | {5{gated}};
      bank_gate_out <= bank_dis & {5{gated}};
      fb_oe_out     <= ~pd | gated;
      fb_gate_out   <= pd & gated;
    end
  end

  // stop levels
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bank_stop_level_out <= 1'h1;
      fb_stop_level_out   <= 1'h1;
      fb_n_stop_level_out <= 1'h0;
    end else if (clk_en_in) begin
      bank_stop_level_out <= ~cfg_level_reg;
      fb_stop_level_out   <= ~cfg_level_reg;
      fb_n_stop_level_out <= cfg_level_reg;
    end
  end

  // power down halts the input receivers
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      clk_inputs_en_out <= 1'h0;
    end else if (clk_en_in) begin
      clk_inputs_en_out <= pd_n_s;
    end
  end

  // ***************************************************************
  // port select and serial address
  // ***************************************************************
  logic [3:0] strap_idx;

  assign strap_idx = hi_s * dsp_pkg::STRAP_WEIGHT + {2'h0, lo_s};

  // straps held while in test port mode
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      serial_bus_en_out <= 1'h0;
      bus_addr_out      <= dsp_pkg::BUS_ADDR_BASE;
    end else if (clk_en_in) begin
      serial_bus_en_out <= ~sel_s;
      if (!sel_s) begin
        bus_addr_out <= dsp_pkg::BUS_ADDR_BASE + {3'h0, strap_idx};
      end
    end
  end

  // ***************************************************************
  // checks, clk_in domain
  // ***************************************************************
  chk_stop_gated: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    clk_en_in && gated && bank_dis[0]
    |=> bank_oe_out[0] && bank_gate_out[0])
    else $error("gated stop not driven");

  chk_stop_tristate: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    clk_en_in && !gated && bank_dis[4] |=> !bank_oe_out[4])
    else $error("disabled bank still driven");

  chk_stop_levels: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    clk_en_in |=> bank_stop_level_out == !$past(cfg_level_reg)
      && fb_n_stop_level_out == $past(cfg_level_reg))
    else $error("stop level wrong");

  chk_pd_stop: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    clk_en_in && pd |=> !clk_inputs_en_out
      && bank_gate_out == {5{$past(gated)}}
      && fb_oe_out == $past(gated))
    else $error("power down did not stop outputs");

  sequence sel_low_held;
    (clk_en_in && !port_sel_in) [*3];
  endsequence

  chk_serial_sel: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    sel_low_held |=> serial_bus_en_out)
    else $error("serial bus not selected");

  chk_bus_addr: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    clk_en_in && sel_s |=> $stable(bus_addr_out))
    else $error("straps not ignored in test mode");

  // ***************************************************************
  // checks, test clock domain
  // ***************************************************************
  sequence tms_high5;
    tms_in [*5];
  endsequence

  chk_tlr_entry: assert property (
    @(posedge tclk_in) disable iff (!tap_rst_n)
    tms_high5 |=> st == dsp_pkg::ST_TLR)
    else $error("five tms highs missed reset state");

  chk_tap_step: assert property (
    @(posedge tclk_in) disable iff (!tap_rst_n)
    st == dsp_pkg::ST_RTI && tms_in |=> st == dsp_pkg::ST_SEL_DR)
    else $error("controller did not follow tms");

  chk_tdi_capture: assert property (
    @(posedge tclk_in) disable iff (!tap_rst_n)
    st == dsp_pkg::ST_SH_DR |=> bypass_reg == $past(tdi_in))
    else $error("tdi not captured on rising edge");

  chk_tdo_fall: assert property (
    @(negedge tclk_in) disable iff (!tap_rst_n)
    shifting |=> tdo_out == $past(sh_bit))
    else $error("tdo not updated on falling edge");

  chk_tdo_idle: assert property (
    @(posedge tclk_in) disable iff (!tap_rst_n)
    tdo_oe_out == shifting)
    else $error("tdo driven while not shifting");

  chk_trst_async: assert property (
    @(posedge tclk_in) disable iff (!reset_n_in)
    !trst_n_in || !port_sel_in |-> st == dsp_pkg::ST_TLR)
    else $error("test reset not asynchronous");

endmodule
